// file: bench/pin_side_model.sv
// outside circuits on the four terminals: drive them or leave them released
// assumes the device's oe and level outputs; released lines sit on a pull-up
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// terminal wire resolution
module pin_side_model (
	input  wire logic [3:0] dev_oe,
	input  wire logic [3:0] dev_level,
	input  wire logic [3:0] ext_en,
	input  wire logic [3:0] ext_val,
	output logic      [3:0] wire_level
);
	// the device wins while it drives; released lines read high, so open drain works
	always_comb begin
		for (int k = 0; k < 4; k++) begin
			if (dev_oe[k])
				wire_level[k] = dev_level[k];
			else if (ext_en[k])
				wire_level[k] = ext_val[k];
			else
				wire_level[k] = 1'b1;
		end
	end
endmodule

`default_nettype wire

// file: bench/pll_pin_function_mux_bench.sv
// self-checking bench for the pin function multiplexer
// assumes the design package and the pin-side model are compiled first
`timescale 1ns/1ps
`default_nettype none

module pll_pin_function_mux_bench;
	import pll_pin_mux_pkg::*;
	logic         hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0]  haddr, hwdata, hrdata;
	logic [1:0]   htrans;
	logic [2:0]   hsize, routed, d;
	core_status_t cs;
	logic [3:0]   pin_w, oe, lvl, ext_en, ext_val;
	logic [7:0]   rst_exp [4];
	int           err_total, checked;

	// ==========================================================
	// design and outside circuits
	pll_pin_function_mux pll_pin_function_mux_i (
		.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .core_status(cs),
		.trigger_pin_one(pin_w[0]), .trigger_pin_one_level(lvl[0]), .trigger_pin_one_oe(oe[0]),
		.trigger_pin_two(pin_w[1]), .trigger_pin_two_level(lvl[1]), .trigger_pin_two_oe(oe[1]),
		.modulation_pin(pin_w[2]), .modulation_pin_level(lvl[2]), .modulation_pin_oe(oe[2]),
		.status_out_pin(pin_w[3]), .status_out_pin_level(lvl[3]), .status_out_pin_oe(oe[3]),
		.routed_level(routed)
	);
	pin_side_model pin_side_model_i (
		.dev_oe(oe), .dev_level(lvl), .ext_en(ext_en), .ext_val(ext_val), .wire_level(pin_w)
	);

	// ==========================================================
	// expectations
	function automatic logic src(input logic [5:0] s, input core_status_t c,
		input logic [2:0] p);
		logic [63:0] v;
		v = '0;
		v[6:4] = p;
		v[7] = c.readback;
		v[9:8] = {c.frequency_comparator_one, c.frequency_comparator_zero};
		v[10] = c.digital_lock_detector & c.charge_pump_voltage_monitor_good;
		v[14:11] = {c.charge_pump_voltage_monitor_low, c.charge_pump_voltage_monitor_high, c.charge_pump_voltage_monitor_good, c.digital_lock_detector};
		v[19:15] = {c.n_div4, c.n_div2, c.r_div4, c.r_div2, c.ramp_limit};
		v[23:22] = {c.ramp_comparator_one, c.ramp_comparator_zero};
		v[31:28] = {c.ramp_flag1, c.ramp_flag0, c.charge_pump_gain, c.fastlock};
		v[38:32] = {c.ramp_done, c.pump_down_pulse, c.pump_up_pulse, c.r_div,
			c.ramp_trigger_c, c.ramp_trigger_b, c.ramp_trigger_a};
		return v[s];
	endfunction

	// result is {oe, level}
	function automatic logic [1:0] drive(input logic [2:0] dc, input logic s);
		case (dc)
			3'h1: return {~s, 1'b0};
			3'h2: return {1'b1, s};
			3'h4: return 2'b10;
			3'h5: return {s, 1'b0};
			3'h6: return {1'b1, ~s};
			default: return 2'b00;
		endcase
	endfunction

	// ==========================================================
	// compare and bus tasks
	task automatic conclude();
		$display("mismatches %0d, comparisons %0d", err_total, checked);
		if (err_total == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: word %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_pin(input logic [1:0] got, input logic [1:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: pin oe/level %b, expected %b", $time, got, exp);
		end
	endtask

	// no fixed latency assumed: poll ready, give up after a bound
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1) begin
			err_total++;
			conclude();
		end
	endtask

	task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
		output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {22'h0, idx, 2'b00};
		hwrite <= wr;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h0, wd};
		wait_ready();
		rd = hrdata;
	endtask

	task automatic wreg(input logic [7:0] idx, input logic [7:0] wd);
		logic [31:0] rd;
		bus(1'b1, idx, wd, rd);
	endtask

	task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
		logic [31:0] rd;
		bus(1'b0, idx, 8'h00, rd);
		cmp_val(rd, {24'h0, exp});
		cmp_val({31'h0, hresp}, 32'h00000000);
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge hclk);
		@(negedge hclk);
	endtask

	// ==========================================================
	// clock and main sequence
	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end

	initial begin
		hresetn = 1'b0; hsel = 1'b0; htrans = 2'b00; haddr = '0; hwrite = 1'b0;
		hsize = 3'h2; hwdata = '0; cs = '0; ext_en = 4'b0111; ext_val = 4'h0;
		err_total = 0; checked = 0;
		rst_exp = '{8'h08, 8'h10, 8'h18, 8'h38};
		void'($urandom(2508));
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		settle(1);
		for (int k = 0; k < 4; k++) cmp_pin({oe[k], lvl[k]}, 2'b00);
		rdchk(IDX_SEL_MSB, 8'h00);
		for (int k = 0; k < 4; k++) rdchk(IDX_TRIGGER_PIN_ONE + 8'(k), rst_exp[k]);
		wreg(8'h28, 8'hff);
		rdchk(8'h28, 8'h00);
		// every select code including reserved ones, drive codes in turn
		for (int s = 0; s < 64; s++) begin
			d = (s % 7 < 3) ? 3'(s % 7) : 3'(s % 7 + 1);
			wreg(IDX_SEL_MSB, {2'b00, s[5], 5'h00});
			wreg(IDX_STATUS, {s[4:0], d});
			rdchk(IDX_SEL_MSB, {2'b00, s[5], 5'h00});
			rdchk(IDX_STATUS, {s[4:0], d});
			ext_val <= {1'b0, 3'($urandom)};
			repeat (3) begin
				@(posedge hclk);
				cs <= core_status_t'(25'($urandom));
				settle(5);
				cmp_pin({oe[3], lvl[3]}, drive(d, src(6'(s), cs, pin_w[2:0])));
			end
		end
		// route pins in; trigger two still routes itself from its reset select
		wreg(IDX_SEL_MSB, 8'h00);
		wreg(IDX_TRIGGER_PIN_ONE, {5'd1, DRV_INPUT});
		wreg(IDX_MOD, {5'd3, DRV_INPUT});
		repeat (8) begin
			@(posedge hclk);
			ext_val <= {1'b0, 3'($urandom)};
			settle(5);
			cmp_val({29'h0, routed}, {29'h0, ext_val[2:0]});
			cmp_pin({oe[0], lvl[0]}, 2'b00);
		end
		// second reset in mid-run
		@(posedge hclk);
		hresetn <= 1'b0;
		settle(2);
		hresetn <= 1'b1;
		settle(1);
		for (int k = 0; k < 4; k++) cmp_pin({oe[k], lvl[k]}, 2'b00);
		rdchk(IDX_STATUS, 8'h38);
		conclude();
	end
endmodule

`default_nettype wire

// file: logic/pll_pin_function_mux.sv
// pin function multiplexer for two trigger, one modulation and one status terminal
// assumes an AHB-Lite master on hclk and core status signals on the same clock;
// pin inputs are asynchronous and synchronised here
//
// Behaviour
// - 3-bit drive state: 0 float, 1 open drain, 2 push-pull, 3 reserved
// - drive 4 grounds, 5 inverted open drain, 6 inverted push-pull, 7 input
// - all drive states reset to float
// - 6-bit select: low five bits in pin register, msb in shared register
// - select 0 ground, 1-3 route pins in, 4-6 echo synchronised pins
// - select 10 outputs lock detector AND charge-pump monitor good
// - selects 11-14 output lock detector and charge-pump monitor flags
// - select 7 read-back, 8-9 frequency comparators, 15 ramp limit
// - selects 22-23 ramp comparators, 28 fastlock, 29 gain, 30-31 flags
// - selects 16-19, 35 dividers; 32-34 ramp triggers; 36-37 pump; 38 done
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

module pll_pin_function_mux (
	input  wire logic                         hclk,
	input  wire logic                         hresetn,
	input  wire logic                         ce,
	input  wire logic                         hsel,
	input  wire logic [31:0]                  haddr,
	input  wire logic [1:0]                   htrans,
	input  wire logic                         hwrite,
	input  wire logic [2:0]                   hsize,
	input  wire logic [31:0]                  hwdata,
	output logic      [31:0]                  hrdata,
	output logic                              hreadyout,
	output logic                              hresp,
	input  wire pll_pin_mux_pkg::core_status_t core_status,
	input  wire logic                         trigger_pin_one,
	output logic                              trigger_pin_one_level,
	output logic                              trigger_pin_one_oe,
	input  wire logic                         trigger_pin_two,
	output logic                              trigger_pin_two_level,
	output logic                              trigger_pin_two_oe,
	input  wire logic                         modulation_pin,
	output logic                              modulation_pin_level,
	output logic                              modulation_pin_oe,
	input  wire logic                         status_out_pin,
	output logic                              status_out_pin_level,
	output logic                              status_out_pin_oe,
	output logic      [2:0]                   routed_level
);
	import pll_pin_mux_pkg::*;

	// ==========================================================
	// state
	logic [7:0]          sel_msb_r;
	logic [7:0]          cfg_r [NUM_PINS];
	logic [NUM_PINS-1:0] meta_r;
	logic [NUM_PINS-1:0] sync_r;
	logic [NUM_PINS-1:0] level_r;
	logic [NUM_PINS-1:0] oe_r;
	logic [2:0]          routed_r;
	logic                pend_r;
	logic                pend_wr_r;
	logic                pend_map_r;
	logic [7:0]          pend_idx_r;
	logic [31:0]         hrdata_r;
	logic                hready_r;
	logic                hresp_r;
	logic [NUM_PINS-1:0] pins_raw;
	logic [SEL_LAST:0]   src_v;
	logic [SEL_W-1:0]    sel   [NUM_PINS];
	logic [DRV_W-1:0]    drv   [NUM_PINS];
	logic [NUM_PINS-1:0] sig;
	logic                take;

	assign pins_raw = {status_out_pin, modulation_pin, trigger_pin_two, trigger_pin_one};

	// ==========================================================
	// pin synchroniser, two stages
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_r <= '0;
			sync_r <= '0;
		end else if (ce) begin
			meta_r <= pins_raw;
			sync_r <= meta_r;
		end
	end

	// ==========================================================
	// AHB-Lite slave, one wait state on every transfer
	// ce low freezes the slave too: masters must not start transfers then
	assign take = hsel && htrans[1] && hready_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend_r     <= 1'b0;
			pend_wr_r  <= 1'b0;
			pend_map_r <= 1'b0;
			pend_idx_r <= 8'h00;
			hready_r   <= 1'b1;
			hresp_r    <= 1'b0;
		end else if (ce) begin
			if (pend_r) begin
				pend_r   <= 1'b0;
				hready_r <= 1'b1;
			end else if (take) begin
				pend_r     <= 1'b1;
				pend_wr_r  <= hwrite;
				pend_idx_r <= haddr[9:2];
				pend_map_r <= haddr[31:10] == 22'h000000;
				hready_r   <= 1'b0;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sel_msb_r <= RST_SEL_MSB;
			for (int i = 0; i < NUM_PINS; i++) begin
				cfg_r[i] <= {RST_SEL[SEL_W*i +: 5], RST_DRV};
			end
		end else if (ce && pend_r && pend_wr_r && pend_map_r) begin
			unique case (pend_idx_r)
				IDX_SEL_MSB: sel_msb_r <= hwdata[7:0];
				IDX_TRIGGER_PIN_ONE:   cfg_r[0] <= hwdata[7:0];
				IDX_TRIGGER_PIN_TWO:   cfg_r[1] <= hwdata[7:0];
				IDX_MOD:     cfg_r[2] <= hwdata[7:0];
				IDX_STATUS:  cfg_r[3] <= hwdata[7:0];
				default: ;
			endcase
		end
	end

	// unmapped reads return zero, unmapped writes are dropped
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_r <= 32'h00000000;
		end else if (ce && pend_r) begin
			hrdata_r <= 32'h00000000;
			if (!pend_wr_r && pend_map_r) begin
				unique case (pend_idx_r)
					IDX_SEL_MSB: hrdata_r[7:0] <= sel_msb_r;
					IDX_TRIGGER_PIN_ONE:   hrdata_r[7:0] <= cfg_r[0];
					IDX_TRIGGER_PIN_TWO:   hrdata_r[7:0] <= cfg_r[1];
					IDX_MOD:     hrdata_r[7:0] <= cfg_r[2];
					IDX_STATUS:  hrdata_r[7:0] <= cfg_r[3];
					default: ;
				endcase
			end
		end
	end

	// ==========================================================
	// signal sources by select code; reserved codes stay low
	always_comb begin
		src_v = '0;
		src_v[SEL_GND] = 1'b0;
		src_v[SEL_SYNC_FIRST +: 3] = sync_r[2:0];
		src_v[SEL_READBACK] = core_status.readback;
		src_v[SEL_FREQUENCY_COMPARATOR_ZERO] = core_status.frequency_comparator_zero;
		src_v[SEL_FREQUENCY_COMPARATOR_ONE] = core_status.frequency_comparator_one;
		src_v[SEL_LOCK] = core_status.digital_lock_detector & core_status.charge_pump_voltage_monitor_good;
		src_v[SEL_DLD] = core_status.digital_lock_detector;
		src_v[SEL_CPM_GOOD] = core_status.charge_pump_voltage_monitor_good;
		src_v[SEL_CPM_HIGH] = core_status.charge_pump_voltage_monitor_high;
		src_v[SEL_CPM_LOW] = core_status.charge_pump_voltage_monitor_low;
		src_v[SEL_LIMIT] = core_status.ramp_limit;
		src_v[SEL_RDIV2] = core_status.r_div2;
		src_v[SEL_RDIV4] = core_status.r_div4;
		src_v[SEL_NDIV2] = core_status.n_div2;
		src_v[SEL_NDIV4] = core_status.n_div4;
		src_v[SEL_RCMP0] = core_status.ramp_comparator_zero;
		src_v[SEL_RCMP1] = core_status.ramp_comparator_one;
		src_v[SEL_FASTLOCK] = core_status.fastlock;
		src_v[SEL_CPG] = core_status.charge_pump_gain;
		src_v[SEL_FLAG0] = core_status.ramp_flag0;
		src_v[SEL_FLAG1] = core_status.ramp_flag1;
		src_v[SEL_RAMP_TRIGGER_A] = core_status.ramp_trigger_a;
		src_v[SEL_RAMP_TRIGGER_B] = core_status.ramp_trigger_b;
		src_v[SEL_RAMP_TRIGGER_C] = core_status.ramp_trigger_c;
		src_v[SEL_RDIV] = core_status.r_div;
		src_v[SEL_UP] = core_status.pump_up_pulse;
		src_v[SEL_DOWN] = core_status.pump_down_pulse;
		src_v[SEL_CNT_DONE] = core_status.ramp_done;
	end

	// ==========================================================
	// per-terminal select and driver
	for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
		assign sel[i] = {sel_msb_r[SEL_MSB_POS[3*i +: 3]], cfg_r[i][SEL_LSB +: 5]};
		assign drv[i] = cfg_r[i][DRV_LSB +: DRV_W];
		// input codes 1 to 3 leave the source low, so the driver sees a low signal
		assign sig[i] = (int'(sel[i]) <= SEL_LAST) ? src_v[sel[i]] : 1'b0;

		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				level_r[i] <= 1'b0;
				oe_r[i]    <= 1'b0;
			end else if (ce) begin
				unique case (drv[i])
					DRV_OD: begin
						level_r[i] <= 1'b0;
						oe_r[i]    <= !sig[i];
					end
					DRV_PP: begin
						level_r[i] <= sig[i];
						oe_r[i]    <= 1'b1;
					end
					DRV_GND: begin
						level_r[i] <= 1'b0;
						oe_r[i]    <= 1'b1;
					end
					DRV_INV_OD: begin
						level_r[i] <= 1'b0;
						oe_r[i]    <= sig[i];
					end
					DRV_INV_PP: begin
						level_r[i] <= !sig[i];
						oe_r[i]    <= 1'b1;
					end
					default: begin
						// float, reserved and input all release the pin
						level_r[i] <= 1'b0;
						oe_r[i]    <= 1'b0;
					end
				endcase
			end
		end

		a_float_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
			ce && drv[i] == DRV_TRISTATE |=> !oe_r[i]) else $error("floating pin driven");
		a_gnd_hold: assert property (@(posedge hclk) disable iff (!hresetn)
			ce && drv[i] == DRV_GND |=> oe_r[i] && !level_r[i]) else $error("ground not held");
		a_inv_pp: assert property (@(posedge hclk) disable iff (!hresetn)
			ce && drv[i] == DRV_INV_PP |=> oe_r[i] && level_r[i] == !$past(sig[i]))
			else $error("inverted push-pull wrong");
		a_reset_state: assert property (@(posedge hclk) disable iff (!hresetn)
			$rose(hresetn) |-> drv[i] == RST_DRV && !oe_r[i]) else $error("pin not floating");
		a_sel_reset: assert property (@(posedge hclk) disable iff (!hresetn)
			$rose(hresetn) |-> sel[i] == RST_SEL[SEL_W*i +: SEL_W]) else $error("select reset");
		a_od_follow: assert property (@(posedge hclk) disable iff (!hresetn)
			ce && drv[i] == DRV_OD && sel[i] <= 6'(SEL_LAST) |=>
			oe_r[i] == !$past(src_v[sel[i]])) else $error("open drain wrong");
	end

	// ==========================================================
	// pins routed in as inputs to the core
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			routed_r <= 3'h0;
		end else if (ce) begin
			for (int k = 0; k < 3; k++) begin
				routed_r[k] <= 1'b0;
				for (int i = 0; i < NUM_PINS; i++) begin
					if (sel[i] == SEL_IN_FIRST + 6'(k) && sync_r[k]) begin
						routed_r[k] <= 1'b1;
					end
				end
			end
		end
	end

	a_sync_echo: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && drv[3] == DRV_PP && sel[3] == SEL_SYNC_FIRST |=> level_r[3] == $past(sync_r[0]))
		else $error("echo of first trigger wrong");
	a_lock_and: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && drv[3] == DRV_PP && sel[3] == SEL_LOCK |=> level_r[3] ==
		$past(core_status.digital_lock_detector && core_status.charge_pump_voltage_monitor_good))
		else $error("combined lock wrong");
	a_readback_out: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && drv[3] == DRV_PP && sel[3] == SEL_READBACK |=> level_r[3] ==
		$past(core_status.readback)) else $error("read-back wrong");
	a_fastlock_out: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && drv[0] == DRV_PP && sel[0] == SEL_FASTLOCK |=> level_r[0] ==
		$past(core_status.fastlock)) else $error("fastlock wrong");
	a_divider_out: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && drv[1] == DRV_PP && sel[1] == SEL_RDIV |=> level_r[1] ==
		$past(core_status.r_div)) else $error("divider wrong");
	a_write_lands: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && take && hwrite && haddr == {22'h0, IDX_TRIGGER_PIN_ONE, 2'b00} ##1 ce |=>
		cfg_r[0] == $past(hwdata[7:0]) && hready_r) else $error("write lost");

	// ==========================================================
	// outputs
	assign hrdata    = hrdata_r;
	assign hreadyout = hready_r;
	assign hresp     = hresp_r;
	assign trigger_pin_one_level = level_r[0];
	assign trigger_pin_one_oe    = oe_r[0];
	assign trigger_pin_two_level = level_r[1];
	assign trigger_pin_two_oe    = oe_r[1];
	assign modulation_pin_level  = level_r[2];
	assign modulation_pin_oe     = oe_r[2];
	assign status_out_pin_level  = level_r[3];
	assign status_out_pin_oe     = oe_r[3];
	assign routed_level = routed_r;

endmodule

`default_nettype wire

// file: logic/pll_pin_mux_pkg.sv
// constants and carriers for the four-terminal pin function multiplexer
// assumes one 40 MHz bus clock; register indices are word indices on the bus
package pll_pin_mux_pkg;

	// ==========================================================
	// register map: word index, byte address is four times it
	localparam logic [7:0] IDX_SEL_MSB = 8'h23;
	localparam logic [7:0] IDX_TRIGGER_PIN_ONE   = 8'h24;
	localparam logic [7:0] IDX_TRIGGER_PIN_TWO   = 8'h25;
	localparam logic [7:0] IDX_MOD     = 8'h26;
	localparam logic [7:0] IDX_STATUS  = 8'h27;

	// ==========================================================
	// field layout
	localparam int NUM_PINS = 4;
	localparam int DRV_LSB  = 0;
	localparam int DRV_W    = 3;
	localparam int SEL_LSB  = 3;
	localparam int SEL_W    = 6;
	// position of each pin's select msb in the shared register, pin 3 first
	localparam logic [11:0] SEL_MSB_POS = {3'h5, 3'h7, 3'h4, 3'h3};

	// ==========================================================
	// reset values
	localparam logic [7:0]  RST_SEL_MSB = 8'h00;
	localparam logic [2:0]  RST_DRV     = 3'h0;
	// select reset per pin, pin 3 first
	localparam logic [23:0] RST_SEL = {6'h07, 6'h03, 6'h02, 6'h01};

	// ==========================================================
	// drive-state codes
	localparam logic [2:0] DRV_TRISTATE = 3'h0, DRV_OD = 3'h1, DRV_PP = 3'h2;
	localparam logic [2:0] DRV_GND = 3'h4, DRV_INV_OD = 3'h5, DRV_INV_PP = 3'h6;
	localparam logic [2:0] DRV_INPUT = 3'h7;

	// ==========================================================
	// select codes
	localparam logic [5:0] SEL_GND = 6'h00, SEL_IN_FIRST = 6'h01, SEL_SYNC_FIRST = 6'h04;
	localparam logic [5:0] SEL_READBACK = 6'h07, SEL_FREQUENCY_COMPARATOR_ZERO = 6'h08, SEL_FREQUENCY_COMPARATOR_ONE = 6'h09;
	localparam logic [5:0] SEL_LOCK = 6'h0a, SEL_DLD = 6'h0b, SEL_CPM_GOOD = 6'h0c;
	localparam logic [5:0] SEL_CPM_HIGH = 6'h0d, SEL_CPM_LOW = 6'h0e, SEL_LIMIT = 6'h0f;
	localparam logic [5:0] SEL_RDIV2 = 6'h10, SEL_RDIV4 = 6'h11, SEL_NDIV2 = 6'h12;
	localparam logic [5:0] SEL_NDIV4 = 6'h13, SEL_RCMP0 = 6'h16, SEL_RCMP1 = 6'h17;
	localparam logic [5:0] SEL_FASTLOCK = 6'h1c, SEL_CPG = 6'h1d, SEL_FLAG0 = 6'h1e;
	localparam logic [5:0] SEL_FLAG1 = 6'h1f, SEL_RAMP_TRIGGER_A = 6'h20, SEL_RAMP_TRIGGER_B = 6'h21;
	localparam logic [5:0] SEL_RAMP_TRIGGER_C = 6'h22, SEL_RDIV = 6'h23, SEL_UP = 6'h24;
	localparam logic [5:0] SEL_DOWN = 6'h25, SEL_CNT_DONE = 6'h26;
	localparam int SEL_LAST = 38;

	// ==========================================================
	// internal signals offered to the terminals, all on the bus clock
	typedef struct packed {
		logic readback;
		logic frequency_comparator_zero;
		logic frequency_comparator_one;
		logic digital_lock_detector;
		logic charge_pump_voltage_monitor_good;
		logic charge_pump_voltage_monitor_high;
		logic charge_pump_voltage_monitor_low;
		logic ramp_limit;
		logic r_div2;
		logic r_div4;
		logic n_div2;
		logic n_div4;
		logic ramp_comparator_zero;
		logic ramp_comparator_one;
		logic fastlock;
		logic charge_pump_gain;
		logic ramp_flag0;
		logic ramp_flag1;
		logic ramp_trigger_a;
		logic ramp_trigger_b;
		logic ramp_trigger_c;
		logic r_div;
		logic pump_up_pulse;
		logic pump_down_pulse;
		logic ramp_done;
	} core_status_t;

endpackage
